// >>> src/adcmp_defines.svh
// Purpose: Constants for the converter mode control and output port.
// Assumes: Included by its bare name from the package and the top module.
// Notes: Field positions refer to the mode register at index zero.
`ifndef ADCMP_DEFINES_SVH
`define ADCMP_DEFINES_SVH

`define ADCMP_WORD_W 16
`define ADCMP_PAIRS 8
`define ADCMP_PIPE_STAGES 6
`define ADCMP_LATENCY 7
`define ADCMP_MODE_REGS 4
`define ADCMP_BYTE_W 8
`define ADCMP_CNT_W 4
`define ADCMP_LAST_BIT 4'h7
`define ADCMP_CNT_ZERO 4'h0
`define ADCMP_CNT_ONE 4'h1
`define ADCMP_RD_BIT 7
`define ADCMP_MODE_IDX 0
`define ADCMP_B_DDR 0
`define ADCMP_B_GAIN 1
`define ADCMP_B_RAND 2
`define ADCMP_B_DELAY 3
`define ADCMP_B_DRIVE 4
`define ADCMP_REG_RST 8'h00
`define ADCMP_PINS 5
`define ADCMP_P_SEL 0
`define ADCMP_P_CS 1
`define ADCMP_P_SCK 2
`define ADCMP_P_SDI 3
`define ADCMP_P_PD 4
`define ADCMP_PIN_RST 5'h02
`define ADCMP_XCFG_W 5
`define ADCMP_XCFG_RST 5'h00

`endif

// >>> src/adcmp_pkg.sv
// Purpose: Shared types for the converter mode control and output port.
// Assumes: The defines header sits beside this file.
// Notes: Holds types only; numbers live in the header.
`include "adcmp_defines.svh"

package adcmp_pkg;

   typedef logic [`ADCMP_WORD_W-1:0] adcmp_word_t;
   typedef logic [`ADCMP_BYTE_W-1:0] adcmp_byte_t;

   typedef enum logic [1:0] {
      ADCMP_SP_IDLE,
      ADCMP_SP_CMD,
      ADCMP_SP_DATA
   } adcmp_sp_state_t;

endpackage : adcmp_pkg

// >>> src/adcmp_top.sv
// Purpose: Mode control, configuration port and output port of the converter.
// Assumes: clk is 250 MHz; encode_pos is the encode clock; pins are async.
// Notes: Configuration lives on clk; sampling and output on encode_pos.
`timescale 1ns/100ps
`include "adcmp_defines.svh"

module adcmp_top #(
   parameter int MODE_REGS = `ADCMP_MODE_REGS
) (
   // Control clock.
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Mode and configuration pins.
   input wire logic program_style_select,
   input wire logic chip_select_n,
   input wire logic serial_clock,
   input wire logic serial_in,
   output logic serial_out_o,
   output logic serial_out_oe,
   input wire logic power_down_pin,
   // Encode clock and converter core.
   input wire logic encode_pos,
   input adcmp_pkg::adcmp_word_t core_word,
   input wire logic core_over,
   output logic sample_track,
   output logic front_gain_select,
   output logic analog_power_en,
   // Output port.
   output adcmp_pkg::adcmp_word_t data_pins,
   output logic output_strobe_pos,
   output logic output_strobe_neg,
   output logic range_exceeded_flag,
   output logic unused_pin,
   output logic output_drive_en,
   output logic lvds_drive_3p5
);
   import adcmp_pkg::*;

   localparam int IDX_W = (MODE_REGS > 1) ? $clog2(MODE_REGS) : 1;

   if (MODE_REGS < 1 || MODE_REGS > 128) begin : g_bad_regs
      $error("MODE_REGS must lie between 1 and 128");
   end

   // Pin synchronisers: three stages, a level counts once two and three agree.
   logic [`ADCMP_PINS-1:0] pin_raw;
   logic [`ADCMP_PINS-1:0] pin_s1;
   logic [`ADCMP_PINS-1:0] pin_s2;
   logic [`ADCMP_PINS-1:0] pin_s3;
   logic [`ADCMP_PINS-1:0] pin_f;

   assign pin_raw = {power_down_pin, serial_in, serial_clock, chip_select_n,
                     program_style_select};

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_s1 <= `ADCMP_PIN_RST;
         pin_s2 <= `ADCMP_PIN_RST;
         pin_s3 <= `ADCMP_PIN_RST;
         pin_f <= `ADCMP_PIN_RST;
      end else if (ce) begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_f <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
      end
   end

   logic par_mode;
   logic cs_s;
   logic sck_s;
   logic sdi_s;
   logic pd_s;
   assign par_mode = pin_f[`ADCMP_P_SEL];
   assign cs_s = pin_f[`ADCMP_P_CS];
   assign sck_s = pin_f[`ADCMP_P_SCK];
   assign sdi_s = pin_f[`ADCMP_P_SDI];
   assign pd_s = pin_f[`ADCMP_P_PD];

   // Serial configuration port.
   adcmp_sp_state_t sp_state;
   logic sck_prev;
   logic [`ADCMP_CNT_W-1:0] bit_cnt;
   adcmp_byte_t cmd_shift;
   adcmp_byte_t wr_shift;
   adcmp_byte_t rd_shift;
   adcmp_byte_t mode_reg [MODE_REGS];
   logic sdo_low;
   logic sck_rise;
   logic sck_fall;
   logic sp_active;
   adcmp_byte_t next_cmd;
   adcmp_byte_t next_wr;
   logic [IDX_W-1:0] cmd_idx;

   assign sp_active = !par_mode && !cs_s;
   assign sck_rise = sp_active && sck_s && !sck_prev;
   assign sck_fall = sp_active && !sck_s && sck_prev;
   assign next_cmd = {cmd_shift[`ADCMP_BYTE_W-2:0], sdi_s};
   assign next_wr = {wr_shift[`ADCMP_BYTE_W-2:0], sdi_s};
   assign cmd_idx = cmd_shift[IDX_W-1:0];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sck_prev <= 1'b0;
      end else if (ce) begin
         sck_prev <= sck_s;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sp_state <= ADCMP_SP_IDLE;
         bit_cnt <= `ADCMP_CNT_ZERO;
         cmd_shift <= `ADCMP_REG_RST;
         wr_shift <= `ADCMP_REG_RST;
      end else if (ce) begin
         if (!sp_active) begin
            sp_state <= ADCMP_SP_IDLE;
            bit_cnt <= `ADCMP_CNT_ZERO;
         end else begin
            case (sp_state)
               ADCMP_SP_IDLE: begin
                  sp_state <= ADCMP_SP_CMD;
                  bit_cnt <= `ADCMP_CNT_ZERO;
               end
               ADCMP_SP_CMD: begin
                  if (sck_rise) begin
                     cmd_shift <= next_cmd;
                     if (bit_cnt == `ADCMP_LAST_BIT) begin
                        sp_state <= ADCMP_SP_DATA;
                        bit_cnt <= `ADCMP_CNT_ZERO;
                     end else begin
                        bit_cnt <= bit_cnt + `ADCMP_CNT_ONE;
                     end
                  end
               end
               ADCMP_SP_DATA: begin
                  if (sck_rise) begin
                     wr_shift <= next_wr;
                     if (bit_cnt == `ADCMP_LAST_BIT) begin
                        sp_state <= ADCMP_SP_CMD;
                        bit_cnt <= `ADCMP_CNT_ZERO;
                     end else begin
                        bit_cnt <= bit_cnt + `ADCMP_CNT_ONE;
                     end
                  end
               end
               default: begin
                  sp_state <= ADCMP_SP_IDLE;
               end
            endcase
         end
      end
   end

   // Register writes land on the eighth data bit of a write frame.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < MODE_REGS; i++) begin
            mode_reg[i] <= `ADCMP_REG_RST;
         end
      end else if (ce) begin
         if (sp_state == ADCMP_SP_DATA && sck_rise &&
             bit_cnt == `ADCMP_LAST_BIT && !cmd_shift[`ADCMP_RD_BIT] &&
             int'(cmd_shift[`ADCMP_RD_BIT-1:0]) < MODE_REGS) begin
            mode_reg[cmd_idx] <= next_wr;
         end
      end
   end

   // Readback: loaded after the command byte, shifted on falling clock.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_shift <= `ADCMP_REG_RST;
         sdo_low <= 1'b0;
      end else if (ce) begin
         if (!sp_active) begin
            sdo_low <= 1'b0;
         end else if (sp_state == ADCMP_SP_CMD && sck_rise &&
                      bit_cnt == `ADCMP_LAST_BIT) begin
            if (next_cmd[`ADCMP_RD_BIT] &&
                int'(next_cmd[`ADCMP_RD_BIT-1:0]) < MODE_REGS) begin
               rd_shift <= mode_reg[next_cmd[IDX_W-1:0]];
            end else begin
               rd_shift <= `ADCMP_REG_RST;
            end
         end else if (sp_state == ADCMP_SP_DATA && sck_fall &&
                      cmd_shift[`ADCMP_RD_BIT]) begin
            sdo_low <= !rd_shift[`ADCMP_BYTE_W-1];
            rd_shift <= {rd_shift[`ADCMP_BYTE_W-2:0], 1'b0};
         end else if (sp_state != ADCMP_SP_DATA && sck_fall) begin
            sdo_low <= 1'b0;
         end
      end
   end

   assign serial_out_o = 1'b0;
   assign serial_out_oe = sdo_low;

   // Effective modes, taken from the pins or the mode register.
   logic cfg_ddr;
   logic cfg_rand;
   logic cfg_delay;
   adcmp_byte_t mode_word;
   assign mode_word = mode_reg[`ADCMP_MODE_IDX];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfg_ddr <= 1'b0;
         front_gain_select <= 1'b0;
         cfg_rand <= 1'b0;
         cfg_delay <= 1'b0;
         lvds_drive_3p5 <= 1'b0;
      end else if (ce) begin
         if (par_mode) begin
            cfg_ddr <= cs_s;
            lvds_drive_3p5 <= cs_s;
            front_gain_select <= sck_s;
            cfg_rand <= sdi_s;
            cfg_delay <= 1'b0;
         end else begin
            cfg_ddr <= mode_word[`ADCMP_B_DDR];
            lvds_drive_3p5 <= mode_word[`ADCMP_B_DRIVE];
            front_gain_select <= mode_word[`ADCMP_B_GAIN];
            cfg_rand <= mode_word[`ADCMP_B_RAND];
            cfg_delay <= mode_word[`ADCMP_B_DELAY];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         output_drive_en <= 1'b0;
         analog_power_en <= 1'b0;
      end else if (ce) begin
         output_drive_en <= !pd_s;
         analog_power_en <= !pd_s;
      end
   end

   // Encode domain: reset and quasi-static settings cross by two flops.
   logic enc_rst_s1;
   logic enc_rst_n;
   logic [`ADCMP_XCFG_W-1:0] xcfg_s1;
   logic [`ADCMP_XCFG_W-1:0] xcfg_s2;
   logic ddr_e;
   logic rand_e;
   logic delay_e;
   logic ce_e;

   always_ff @(posedge encode_pos) begin
      enc_rst_s1 <= rst_n;
      enc_rst_n <= enc_rst_s1;
   end

   always_ff @(posedge encode_pos) begin
      if (!enc_rst_n) begin
         xcfg_s1 <= `ADCMP_XCFG_RST;
         xcfg_s2 <= `ADCMP_XCFG_RST;
      end else begin
         xcfg_s1 <= {ce, cfg_delay, cfg_rand, cfg_ddr, 1'b0};
         xcfg_s2 <= xcfg_s1;
      end
   end

   assign ce_e = xcfg_s2[4];
   assign delay_e = xcfg_s2[3];
   assign rand_e = xcfg_s2[2];
   assign ddr_e = xcfg_s2[1];

   // Track while encode is low; the rising edge holds the sample.
   assign sample_track = !encode_pos;

   // Six converter stages plus the correction step give seven edges.
   logic [`ADCMP_WORD_W:0] pipe [`ADCMP_LATENCY];
   adcmp_word_t rnd_word;
   adcmp_word_t even_pins;
   logic [`ADCMP_WORD_W:0] tail;

   assign tail = pipe[`ADCMP_LATENCY-1];
   assign rnd_word = rand_e ?
      {tail[`ADCMP_WORD_W-1:1] ^ {(`ADCMP_WORD_W-1){tail[0]}}, tail[0]} :
      tail[`ADCMP_WORD_W-1:0];

   always_ff @(posedge encode_pos) begin
      if (!enc_rst_n) begin
         for (int i = 0; i < `ADCMP_LATENCY; i++) begin
            pipe[i] <= '0;
         end
      end else if (ce_e) begin
         pipe[0] <= {core_over, core_word};
         for (int i = 1; i < `ADCMP_LATENCY; i++) begin
            pipe[i] <= pipe[i-1];
         end
      end
   end

   // Output stage: seventh edge after the sample.
   always_ff @(posedge encode_pos) begin
      if (!enc_rst_n) begin
         even_pins <= '0;
         range_exceeded_flag <= 1'b0;
         unused_pin <= 1'b0;
      end else if (ce_e) begin
         range_exceeded_flag <= tail[`ADCMP_WORD_W];
         unused_pin <= ddr_e && !tail[`ADCMP_WORD_W];
         for (int k = 0; k < `ADCMP_PAIRS; k++) begin
            if (ddr_e) begin
               even_pins[2*k+1] <= rnd_word[2*k];
               even_pins[2*k] <= !rnd_word[2*k];
            end else begin
               even_pins[2*k+1] <= rnd_word[2*k+1];
               even_pins[2*k] <= rnd_word[2*k];
            end
         end
      end
   end

   // Odd bits are held beside the even ones and shown while encode is low.
   logic [`ADCMP_WORD_W-1:0] odd_src;
   always_ff @(posedge encode_pos) begin
      if (!enc_rst_n) begin
         odd_src <= '0;
      end else if (ce_e) begin
         odd_src <= rnd_word;
      end
   end

   // With the delay bit clear, strobe low while encode high, so data changes on its falling edge.
   assign data_pins = (ddr_e && !encode_pos) ?
      odd_data(odd_src) : even_pins;
   assign output_strobe_pos = delay_e ? encode_pos : !encode_pos;
   assign output_strobe_neg = !output_strobe_pos;

   function automatic adcmp_word_t odd_data(input adcmp_word_t w);
      adcmp_word_t r;
      r = '0;
      for (int k = 0; k < `ADCMP_PAIRS; k++) begin
         r[2*k+1] = w[2*k+1];
         r[2*k] = !w[2*k+1];
      end
      odd_data = r;
   endfunction : odd_data

   // Checks.
   AST_PAR_DDR: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && par_mode) |=> (cfg_ddr == $past(cs_s) &&
                            lvds_drive_3p5 == $past(cs_s)))
      else $error("parallel output format not taken from chip select");
   AST_PAR_GAIN: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && par_mode && sck_s) |=> front_gain_select)
      else $error("parallel gain not taken from serial clock");
   AST_PAR_RAND: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && par_mode && !sdi_s) |=> !cfg_rand)
      else $error("randomization on while serial input low");
   AST_CS_HIGH_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && (cs_s || par_mode)) |=> (sp_state == ADCMP_SP_IDLE))
      else $error("serial port active without chip select");
   AST_SDO_SERIAL: assert property (@(posedge clk) disable iff (!rst_n)
      serial_out_oe |-> (!par_mode && sp_state != ADCMP_SP_IDLE
                         && cmd_shift[`ADCMP_RD_BIT]))
      else $error("readback pin driven outside a read frame");
   AST_PD_HIZ: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && pd_s) |=> (!output_drive_en && !analog_power_en))
      else $error("outputs driven in power down");
   AST_LATENCY: assert property (@(posedge encode_pos) disable iff (!enc_rst_n)
      (ce_e [*8] ##0 (!ddr_e && !rand_e)) |=>
      (ddr_e || data_pins == $past(core_word, 8)))
      else $error("output word not seven encode cycles after sample");
   AST_PIPE7: assert property (@(posedge encode_pos) disable iff (!enc_rst_n)
      (ce_e [*8]) |=> (range_exceeded_flag == $past(core_over, 8)))
      else $error("range flag not seven encode cycles after sample");
   AST_OF_NEG: assert property (@(posedge encode_pos) disable iff (!enc_rst_n)
      ($past(ce_e) && ddr_e && $past(ddr_e)) |->
      (unused_pin == !range_exceeded_flag))
      else $error("negative range leg not the complement");

endmodule : adcmp_top

// >>> testbench/adcmp_capture_model.sv
// Purpose: Capture side and readback pull-up facing the converter port.
// Assumes: Captured words are only meaningful in full-rate mode.
// Notes: Words are taken on the forwarded strobe, never on encode.
`timescale 1ns/100ps

module adcmp_capture_model (
   // Readback pin.
   input wire logic serial_out_oe,
   output logic sdo_line,
   // Output port.
   input wire logic output_strobe_pos,
   input wire logic output_drive_en,
   input adcmp_pkg::adcmp_word_t data_pins,
   input wire logic range_exceeded_flag,
   output adcmp_pkg::adcmp_word_t cap_word,
   output logic cap_over
);
   import adcmp_pkg::*;
   adcmp_word_t pins_seen;

   // The external pull-up lifts the line whenever the pin is released.
   assign sdo_line = serial_out_oe ? 1'b0 : 1'b1;
   // Output pins that are not driven float.
   assign pins_seen = output_drive_en ? data_pins : 16'hZZZZ;

   // With the delay bit clear, words change with the falling strobe, so the rising strobe is mid-eye.
   always_ff @(posedge output_strobe_pos) begin
      cap_word <= pins_seen;
      cap_over <= range_exceeded_flag;
   end
endmodule : adcmp_capture_model

// >>> testbench/adcmp_top_tb_top.sv
// Purpose: Self-checking bench for the converter mode and output port.
// Assumes: Encode runs at 30 ns, unrelated in phase to the 4 ns clock.
// Notes: Expected words come from a log of the core samples driven.
`timescale 1ns/100ps

`define CHK(act, exp) begin \
   checks++; \
   if ((act) !== (exp)) begin \
      error_cnt++; \
      $display("ERROR t=%0t got %0h exp %0h", $time, (act), (exp)); \
   end \
end

module adcmp_top_tb_top;
   import adcmp_pkg::*;
   logic clk = 1'b0;
   logic encode_pos = 1'b0;
   logic rst_n = 1'b0;
   logic program_style_select = 1'b0;
   logic chip_select_n = 1'b1;
   logic serial_clock = 1'b0;
   logic serial_in = 1'b0;
   logic power_down_pin = 1'b0;
   adcmp_word_t core_word = 16'h0001;
   logic core_over = 1'b0;
   logic serial_out_o, serial_out_oe, sample_track, front_gain_select;
   logic analog_power_en, output_strobe_pos, output_strobe_neg;
   logic range_exceeded_flag, unused_pin, output_drive_en, lvds_drive_3p5;
   logic sdo_line, cap_over;
   adcmp_word_t data_pins, cap_word;
   adcmp_word_t hist_w[$];
   logic hist_o[$];
   int error_cnt = 0;
   int checks = 0;
   adcmp_byte_t rd;

   initial begin
      forever #2 clk = ~clk;
   end
   // About 33 Msps, inside the full-rate format's comfort zone.
   initial begin
      #7;
      forever #15 encode_pos = ~encode_pos;
   end

   // Every sample taken is logged, then the next one is offered.
   always @(posedge encode_pos) begin
      hist_w.push_back(core_word);
      hist_o.push_back(core_over);
      core_word <= core_word * 16'h0005 + 16'h3A71;
      core_over <= core_word[2];
   end

   adcmp_top adcmp_top_i (
      .clk(clk), .rst_n(rst_n), .ce(1'b1),
      .program_style_select(program_style_select),
      .chip_select_n(chip_select_n), .serial_clock(serial_clock),
      .serial_in(serial_in), .serial_out_o(serial_out_o),
      .serial_out_oe(serial_out_oe), .power_down_pin(power_down_pin),
      .encode_pos(encode_pos), .core_word(core_word),
      .core_over(core_over), .sample_track(sample_track),
      .front_gain_select(front_gain_select),
      .analog_power_en(analog_power_en), .data_pins(data_pins),
      .output_strobe_pos(output_strobe_pos),
      .output_strobe_neg(output_strobe_neg),
      .range_exceeded_flag(range_exceeded_flag), .unused_pin(unused_pin),
      .output_drive_en(output_drive_en), .lvds_drive_3p5(lvds_drive_3p5)
   );

   adcmp_capture_model adcmp_capture_model_i (
      .serial_out_oe(serial_out_oe), .sdo_line(sdo_line),
      .output_strobe_pos(output_strobe_pos),
      .output_drive_en(output_drive_en), .data_pins(data_pins),
      .range_exceeded_flag(range_exceeded_flag),
      .cap_word(cap_word), .cap_over(cap_over)
   );

   task automatic report_and_stop;
      $display("Checks %0d, errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop

   task automatic wait_drive(input logic val);
      int n;
      n = 0;
      while (output_drive_en !== val) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 64) begin
            error_cnt++;
            report_and_stop();
         end
      end
   endtask : wait_drive

   // The strap only moves while the part is held in reset.
   task automatic do_reset(input logic par);
      @(posedge clk);
      rst_n <= 1'b0;
      program_style_select <= par;
      repeat (5) @(posedge clk);
      repeat (3) @(posedge encode_pos);
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (12) @(posedge clk);
      wait_drive(1'b1);
      @(posedge clk);
   endtask : do_reset

   task automatic sp_byte(input adcmp_byte_t tx, output adcmp_byte_t rx);
      for (int i = 7; i >= 0; i--) begin
         serial_in <= tx[i];
         repeat (8) @(posedge clk);
         serial_clock <= 1'b1;
         repeat (8) @(posedge clk);
         rx[i] = sdo_line;
         serial_clock <= 1'b0;
      end
   endtask : sp_byte

   task automatic sp_frame(input adcmp_byte_t cmd, input adcmp_byte_t dat,
                           output adcmp_byte_t rx);
      adcmp_byte_t junk;
      @(posedge clk);
      chip_select_n <= 1'b0;
      repeat (8) @(posedge clk);
      sp_byte(cmd, junk);
      sp_byte(dat, rx);
      repeat (8) @(posedge clk);
      chip_select_n <= 1'b1;
      repeat (16) @(posedge clk);
   endtask : sp_frame

   function automatic adcmp_word_t ddr_pins(adcmp_word_t w, logic odd);
      adcmp_word_t p;
      for (int k = 0; k < 8; k++) begin
         p[2*k+1] = w[2*k+odd];
         p[2*k] = ~w[2*k+odd];
      end
      return p;
   endfunction : ddr_pins

   // Checks each output word against the sample taken seven edges before.
   task automatic run_stream(input logic ddr, input logic rnd,
                             input logic dly, input int n);
      adcmp_word_t e;
      logic o;
      repeat (12) @(posedge encode_pos);
      repeat (n) begin
         @(posedge encode_pos);
         #1;
         e = hist_w[hist_w.size() - 8];
         o = hist_o[hist_o.size() - 8];
         if (rnd) begin
            e[15:1] = e[15:1] ^ {15{e[0]}};
         end
         `CHK(sample_track, 1'b0)
         `CHK(output_strobe_pos, dly)
         `CHK(output_strobe_neg, ~dly)
         `CHK(range_exceeded_flag, o)
         `CHK(unused_pin, ddr & ~o)
         if (ddr) begin
            `CHK(data_pins, ddr_pins(e, 1'b0))
         end else begin
            `CHK(data_pins, e)
         end
         @(negedge encode_pos);
         #1;
         `CHK(sample_track, 1'b1)
         `CHK(output_strobe_pos, ~dly)
         if (ddr) begin
            `CHK(data_pins, ddr_pins(e, 1'b1))
         end else begin
            `CHK(dly ? data_pins : cap_word, e)
            `CHK(dly ? range_exceeded_flag : cap_over, o)
         end
      end
   endtask : run_stream

   initial begin
      do_reset(1'b0);
      `CHK(front_gain_select, 1'b0)
      `CHK(lvds_drive_3p5, 1'b0)
      `CHK(analog_power_en, 1'b1)
      `CHK(serial_out_oe, 1'b0)
      run_stream(1'b0, 1'b0, 1'b0, 10);
      $display("Test reset_and_full_rate done");
      sp_frame(8'h00, 8'h1A, rd);
      `CHK(rd, 8'hFF)
      `CHK(front_gain_select, 1'b1)
      `CHK(lvds_drive_3p5, 1'b1)
      sp_frame(8'h80, 8'h00, rd);
      `CHK(rd, 8'h1A)
      sp_frame(8'h05, 8'hFF, rd);
      sp_frame(8'h85, 8'h00, rd);
      `CHK(rd, 8'h00)
      run_stream(1'b0, 1'b0, 1'b1, 10);
      sp_frame(8'h00, 8'h05, rd);
      sp_byte(8'hFF, rd);
      sp_byte(8'hFF, rd);
      sp_frame(8'h80, 8'h00, rd);
      `CHK(rd, 8'h05)
      run_stream(1'b1, 1'b1, 1'b0, 10);
      $display("Test serial_port done");
      do_reset(1'b1);
      chip_select_n <= 1'b0;
      serial_clock <= 1'b1;
      serial_in <= 1'b1;
      repeat (16) @(posedge clk);
      `CHK(front_gain_select, 1'b1)
      `CHK(lvds_drive_3p5, 1'b0)
      run_stream(1'b0, 1'b1, 1'b0, 10);
      @(posedge clk);
      chip_select_n <= 1'b1;
      serial_clock <= 1'b0;
      serial_in <= 1'b0;
      repeat (16) @(posedge clk);
      `CHK(front_gain_select, 1'b0)
      `CHK(lvds_drive_3p5, 1'b1)
      run_stream(1'b1, 1'b0, 1'b0, 10);
      $display("Test parallel_pins done");
      @(posedge clk);
      power_down_pin <= 1'b1;
      wait_drive(1'b0);
      `CHK(analog_power_en, 1'b0)
      @(posedge clk);
      power_down_pin <= 1'b0;
      wait_drive(1'b1);
      `CHK(analog_power_en, 1'b1)
      $display("Test power_down done");
      report_and_stop();
   end
endmodule : adcmp_top_tb_top
